// [verilog/ofsel_cfg.svh]
// Offsets, field positions, reset values and selection codes of the output function select.
`ifndef OFSEL_CFG_SVH
`define OFSEL_CFG_SVH

// Register byte addresses.
`define OFSEL_REG_CTRL      12'h000
`define OFSEL_REG_STAT      12'h004
`define OFSEL_ADDR_W        12

// Control register fields.
`define OFSEL_CTRL_LSEL_LSB 0
`define OFSEL_CTRL_ASEL_LSB 8
`define OFSEL_CTRL_PWM_LSB  16

// Status register fields.
`define OFSEL_STAT_FN_LSB   0
`define OFSEL_STAT_LOAD_BIT 8
`define OFSEL_STAT_AUX_BIT  9
`define OFSEL_STAT_SOL_BIT  10
`define OFSEL_STAT_LIND_BIT 11
`define OFSEL_STAT_GIND_BIT 12
`define OFSEL_STAT_CONF_BIT 13

// Reset values of the selections and the modulation mode.
`define OFSEL_LSEL_RST      4'h1
`define OFSEL_ASEL_RST      4'h2
`define OFSEL_PWM_RST       2'h0

// Selection codes with a special meaning.
`define OFSEL_SEL_ALARM     4'h8
`define OFSEL_SEL_DIV       4'ha
`define OFSEL_SEL_DIV_INV   4'hb
`define OFSEL_SEL_MAX       4'hb

// Modulation mode bits: bit 0 solar switch, bit 1 load terminal.
`define OFSEL_PWM_SOL_BIT   0
`define OFSEL_PWM_LOAD_BIT  1

`endif

// [verilog/ofsel_pkg.sv]
// Types shared by the output function select modules.
package ofsel_pkg;

   typedef logic [3:0] ofsel_sel_t;
   typedef logic [1:0] ofsel_pwm_t;

   // Index of each internal function in the function vector.
   typedef enum logic [2:0] {
      FN_LBD   = 3'h0,
      FN_GEN   = 3'h1,
      FN_EVENT = 3'h2,
      FN_BAT2  = 3'h3,
      FN_ALARM = 3'h4,
      FN_DIV   = 3'h5
   } ofsel_fn_e;

   localparam int unsigned NUM_FN   = 6;
   localparam int unsigned NUM_TERM = 2;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b01,
      ST_ACCESS = 2'b10
   } ofsel_apb_e;

endpackage

// [verilog/ofsel_route_if.sv]
// Selections, function signals and terminal levels passed between top and router.
`timescale 1ns/100ps
interface ofsel_route_if;
   ofsel_pkg::ofsel_sel_t         sel   [ofsel_pkg::NUM_TERM];
   logic [ofsel_pkg::NUM_FN-1:0]  fn;
   logic [ofsel_pkg::NUM_TERM-1:0] level;

   modport top   (output sel, output fn, input level);
   modport route (input sel, input fn, output level);
endinterface

// [verilog/ofsel_route.sv]
// Combinational routing of one function with polarity onto each terminal.
`timescale 1ns/100ps
`include "ofsel_cfg.svh"
module ofsel_route (
   ofsel_route_if.route rif   // selections in, terminal levels out
);
   genvar t;
   generate
      for (t = 0; t < ofsel_pkg::NUM_TERM; t++) begin : g_term
         logic [2:0] idx;
         logic       inv;
         assign idx = rif.sel[t][3:1];
         // Pairs below 8 are on-while-active when even; alarm and diversion are the reverse.
         assign inv = rif.sel[t][0] ^ (rif.sel[t] >= `OFSEL_SEL_ALARM);
         // Codes above the last selection keep the terminal off.
         always_comb begin
            if (rif.sel[t] > `OFSEL_SEL_MAX) begin
               rif.level[t] = 1'b0;
            end else begin
               rif.level[t] = rif.fn[idx] ^ inv;  // see R1 R2 R3 R4
            end
         end
      end
   endgenerate
endmodule

// [verilog/ofsel_top.sv]
// Output function select: APB registers, terminal routing and indicator drive.
//
// Overview of operation
// R1: Each of the two terminals is driven by one of six functions, picked by its own selection.
// R2: Selections 0 to 7 pair up four functions, even codes on while active, odd codes off.
// R3: Selection 8 turns the terminal off below the alarm voltage and selection 9 turns it on.
// R4: Selection 10 keeps the dump load on for regulation and 11 reverses that polarity.
// R5: After reset the load terminal uses the inverted low-battery disconnect selection.
// R6: Load terminal modulation happens only with selection 10; 11 with modes 2 or 3 is barred.
// R7: The auxiliary terminal only ever switches fully on or off.
// R8: The load indicator lights whenever low-battery disconnect is active.
// R9: The generator indicator lights whenever the generator function asks for a run.
// R10: Solar series switching and diversion through a terminal run side by side.
// R11: Diversion only switches a dump load and never touches the solar or wind source.
// R12: Each terminal follows its function and polarity on every evaluation cycle.
`timescale 1ns/100ps
`include "ofsel_cfg.svh"
module ofsel_top (
   input  wire logic        pclk,              // 200 MHz bus and regulator clock
   input  wire logic        presetn,           // asynchronous reset, active low
   input  wire logic        psel,              // APB select
   input  wire logic        penable,           // APB access phase
   input  wire logic        pwrite,            // APB write
   input  wire logic [11:0] paddr,             // APB byte address
   input  wire logic [31:0] pwdata,            // APB write data
   input  wire logic [3:0]  pstrb,             // APB byte strobes
   output logic             pready,            // APB ready
   output logic [31:0]      prdata,            // APB read data
   output logic             pslverr,           // APB error on unmapped address
   input  wire logic        fn_lbd,            // low-battery disconnect wants load off
   input  wire logic        fn_gen,            // generator function wants a run
   input  wire logic        fn_event,          // event controller event is on
   input  wire logic        fn_bat2,           // second battery should charge
   input  wire logic        fn_below_alarm,    // battery voltage below alarm setting
   input  wire logic        fn_div_disc,       // diversion wants dump load disconnected
   input  wire logic        div_pwm,           // diversion modulated drive, high = dump on
   input  wire logic        sol_level,         // series control slow switching level
   input  wire logic        sol_pwm,           // series control modulated drive
   output logic             load_terminal,     // load terminal switch drive
   output logic             aux_terminal,      // auxiliary terminal switch drive
   output logic             solar_negative_input, // solar input series switch drive
   output logic             load_indicator,    // load indicator on the display
   output logic             generator_indicator // generator indicator on the display
);

   ////////////////////////////////////////////////////////////////////////////////
   // Registers and bus slave.

   ofsel_pkg::ofsel_sel_t lsel_q;
   ofsel_pkg::ofsel_sel_t asel_q;
   ofsel_pkg::ofsel_pwm_t pwm_q;
   ofsel_pkg::ofsel_apb_e st_q;
   logic                  setup;
   logic                  hit_ctrl;
   logic                  hit_stat;
   logic                  conflict;
   logic [31:0]           ctrl_word;
   logic [31:0]           stat_word;

   assign setup    = psel && !penable;
   assign hit_ctrl = paddr == `OFSEL_REG_CTRL;
   assign hit_stat = paddr == `OFSEL_REG_STAT;
   // The inverted diversion selection with load modulation is a configuration fault.
   assign conflict = (lsel_q == `OFSEL_SEL_DIV_INV) && pwm_q[`OFSEL_PWM_LOAD_BIT];

   always_comb begin
      ctrl_word = 32'h0;
      ctrl_word[`OFSEL_CTRL_LSEL_LSB +: 4] = lsel_q;
      ctrl_word[`OFSEL_CTRL_ASEL_LSB +: 4] = asel_q;
      ctrl_word[`OFSEL_CTRL_PWM_LSB +: 2]  = pwm_q;
   end

   always_comb begin
      stat_word = 32'h0;
      stat_word[`OFSEL_STAT_FN_LSB +: ofsel_pkg::NUM_FN] =
         {fn_div_disc, fn_below_alarm, fn_bat2, fn_event, fn_gen, fn_lbd};
      stat_word[`OFSEL_STAT_LOAD_BIT] = load_terminal;
      stat_word[`OFSEL_STAT_AUX_BIT]  = aux_terminal;
      stat_word[`OFSEL_STAT_SOL_BIT]  = solar_negative_input;
      stat_word[`OFSEL_STAT_LIND_BIT] = load_indicator;
      stat_word[`OFSEL_STAT_GIND_BIT] = generator_indicator;
      stat_word[`OFSEL_STAT_CONF_BIT] = conflict;
   end

   // The answer is prepared in the setup cycle so that every access takes one wait-free phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q    <= ofsel_pkg::ST_IDLE;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         unique case (st_q)
            ofsel_pkg::ST_IDLE: begin
               if (setup) begin
                  st_q    <= ofsel_pkg::ST_ACCESS;
                  pready  <= 1'b1;
                  pslverr <= !(hit_ctrl || hit_stat);
                  prdata  <= pwrite ? 32'h0 : hit_ctrl ? ctrl_word : hit_stat ? stat_word : 32'h0;
               end
            end
            ofsel_pkg::ST_ACCESS: begin
               st_q    <= ofsel_pkg::ST_IDLE;
               pready  <= 1'b0;
               pslverr <= 1'b0;
               prdata  <= 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lsel_q <= `OFSEL_LSEL_RST;  // see R5
         asel_q <= `OFSEL_ASEL_RST;
         pwm_q  <= `OFSEL_PWM_RST;
      end else if (psel && penable && pready && pwrite && hit_ctrl) begin
         if (pstrb[0]) begin
            lsel_q <= pwdata[`OFSEL_CTRL_LSEL_LSB +: 4];
         end
         if (pstrb[1]) begin
            asel_q <= pwdata[`OFSEL_CTRL_ASEL_LSB +: 4];
         end
         if (pstrb[2]) begin
            pwm_q <= pwdata[`OFSEL_CTRL_PWM_LSB +: 2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Terminal routing.

   ofsel_route_if rif ();

   assign rif.sel[0] = lsel_q;
   assign rif.sel[1] = asel_q;
   assign rif.fn     = {fn_div_disc, fn_below_alarm, fn_bat2, fn_event, fn_gen, fn_lbd};

   ofsel_route u_route (
      .rif (rif.route)
   );

   logic load_pwm_on;

   // Modulation reaches the load terminal only with the plain diversion selection.
   assign load_pwm_on = pwm_q[`OFSEL_PWM_LOAD_BIT] && (lsel_q == `OFSEL_SEL_DIV);  // see R6

   // One flop stage per evaluation cycle; outputs never wait longer than that.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_terminal <= 1'b0;
         aux_terminal  <= 1'b0;
      end else begin
         load_terminal <= load_pwm_on ? div_pwm : rif.level[0];  // see R12 R6
         aux_terminal  <= rif.level[1];                          // see R7 R12
      end
   end

   // The solar switch never looks at diversion, so both regulators work at once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         solar_negative_input <= 1'b0;
      end else begin
         solar_negative_input <= pwm_q[`OFSEL_PWM_SOL_BIT] ? sol_pwm : sol_level;  // see R10 R11
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_indicator      <= 1'b0;
         generator_indicator <= 1'b0;
      end else begin
         load_indicator      <= fn_lbd;  // see R8
         generator_indicator <= fn_gen;  // see R9
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence apb_setup_s;
      psel && !penable && st_q == ofsel_pkg::ST_IDLE;
   endsequence

   sequence apb_answer_s;
      pready ##1 !pready;
   endsequence

   apb_ready_a: assert property (apb_setup_s |=> apb_answer_s)
      else $error("pready did not pulse one cycle after setup");

   unmapped_err_a: assert property ((apb_setup_s and (!hit_ctrl && !hit_stat)) |=> pslverr && pready)
      else $error("unmapped address gave no error");

   load_ind_a: assert property (fn_lbd |=> load_indicator)  // see R8
      else $error("load indicator not lit during disconnect");

   gen_ind_a: assert property (fn_gen != generator_indicator |=> $changed(generator_indicator))  // see R9
      else $error("generator indicator did not follow generator request");

   lbd_inverted_a: assert property (lsel_q == 4'h1 && fn_lbd |=> !load_terminal)  // see R5
      else $error("load terminal on while disconnect active");

   alarm_off_a: assert property (asel_q == 4'h8 && fn_below_alarm |=> !aux_terminal)  // see R3
      else $error("aux terminal on below alarm with selection 8");

   alarm_on_a: assert property (lsel_q == 4'h9 && fn_below_alarm && !pwm_q[1] |=> load_terminal)  // see R3
      else $error("load terminal off below alarm with selection 9");

   div_pwm_a: assert property (lsel_q == 4'ha && pwm_q[1] |=> load_terminal == $past(div_pwm))  // see R6
      else $error("load terminal did not follow diversion modulation");

   div_inv_a: assert property (lsel_q == 4'hb && !fn_div_disc |=> !load_terminal)  // see R4 R6
      else $error("inverted diversion drove terminal on or modulated");

   aux_full_a: assert property (asel_q == 4'ha |=> aux_terminal == !$past(fn_div_disc))  // see R7
      else $error("aux terminal modulated or wrong diversion polarity");

   // One cycle of the selection would do, since a rewrite at the first edge lands after the aux flop has sampled it.
   gen_sel_a: assert property ((asel_q == 4'h2 && fn_gen) [*2] |=> aux_terminal)  // see R2
      else $error("aux terminal off while generator run requested");

   solar_a: assert property (!pwm_q[0] |=> solar_negative_input == $past(sol_level))  // see R10
      else $error("solar switch disturbed by diversion");

endmodule

// [dv/ofsel_relay_model.sv]
// Behavioural relay or dump load hanging on one switched terminal.
`timescale 1ns/100ps
module ofsel_relay_model (
   input  wire logic pclk,        // regulator clock
   input  wire logic drive,       // terminal level, contact closed when high
   output int        n_close = 0  // closures seen since time zero
);
   logic last_q = 1'b0;

   // The load sits across the battery and only draws current, so no source is opened.
   always @(posedge pclk) begin
      if (drive === 1'b1 && last_q !== 1'b1) begin
         n_close <= n_close + 1;
      end
      last_q <= drive;
   end
endmodule

// [dv/ofsel_bench.sv]
// Self-checking bench for the output function select, with a reference model.
`timescale 1ns/100ps
`include "ofsel_cfg.svh"
module ofsel_bench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hf;
   logic        pready, pslverr, load_terminal, aux_terminal;
   logic        solar_negative_input, load_indicator, generator_indicator;
   logic [31:0] prdata, rd, seed = 32'h58;
   logic        fn_lbd = 1'b0, fn_gen = 1'b0, fn_event = 1'b0, fn_bat2 = 1'b0;
   logic        fn_below_alarm = 1'b0, fn_div_disc = 1'b0;
   logic        div_pwm = 1'b0, sol_level = 1'b0, sol_pwm = 1'b0, err;
   int          n_mismatch = 0, comparisons = 0, cycles = 0, load_closes, aux_closes;

   always #2.5 pclk = ~pclk;

   ofsel_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .pready, .prdata, .pslverr, .fn_lbd, .fn_gen, .fn_event, .fn_bat2, .fn_below_alarm,
      .fn_div_disc, .div_pwm, .sol_level, .sol_pwm, .load_terminal, .aux_terminal,
      .solar_negative_input, .load_indicator, .generator_indicator);
   ofsel_relay_model load_relay (.pclk, .drive(load_terminal), .n_close(load_closes));
   ofsel_relay_model aux_relay (.pclk, .drive(aux_terminal), .n_close(aux_closes));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   // Expected terminal level; mod says the load modulated drive is in use.
   function automatic logic term(input int sel, input logic [6:0] f, input logic mod);
      if (sel < 8) return f[sel/2] ^ (sel % 2 == 1);
      if (sel == 8) return !f[4];
      if (sel == 9) return f[4];
      if (sel == 10) return mod ? f[6] : !f[5];
      if (sel == 11) return f[5];
      return 1'b0;
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Starts one edge on, so a release of psel never meets a new setup in one step.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Four rounds of random function inputs, each answered one edge after it is applied.
   task automatic drive_check(input int ls, input int as, input logic mod, input int pw);
      logic [6:0] f;
      repeat (4) begin
         @(posedge pclk);
         seed = xs(seed);
         f = seed[6:0];
         {div_pwm, fn_div_disc, fn_below_alarm, fn_bat2, fn_event, fn_gen, fn_lbd} <= f;
         sol_level <= seed[7];
         sol_pwm <= seed[8];
         @(posedge pclk);
         #1;
         check("load", load_terminal, term(ls, f, mod));
         check("aux", aux_terminal, term(as, f, 1'b0));
         check("solar", solar_negative_input, (pw % 2 == 1) ? seed[8] : seed[7]);
         check("load ind", load_indicator, f[0]);
         check("gen ind", generator_indicator, f[1]);
      end
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         final_report;
      end
   end

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFSEL_REG_CTRL, 32'h0, rd, err);
      check("ctrl reset", rd, 32'h0000_0201);
      apb(1'b0, 12'h010, 32'h0, rd, err);
      check("unmapped error", {31'h0, err}, 32'h1);
      // Every selection on both terminals under every modulation mode.
      for (int pw = 0; pw < 4; pw++) begin
         for (int s = 0; s < 12; s++) begin
            apb(1'b1, `OFSEL_REG_CTRL, (pw << 16) | ((11 - s) << 8) | s, rd, err);
            apb(1'b0, `OFSEL_REG_STAT, 32'h0, rd, err);
            check("conflict flag", {31'h0, rd[13]}, {31'h0, s == 11 && pw >= 2});
            drive_check(s, 11 - s, s == 10 && pw >= 2, pw);
         end
      end
      // Byte strobes, an ignored unmapped write and the codes above the last selection.
      pstrb <= 4'h1;
      apb(1'b1, `OFSEL_REG_CTRL, 32'h0000_0c0f, rd, err);
      pstrb <= 4'h2;
      apb(1'b1, `OFSEL_REG_CTRL, 32'h0000_0c0f, rd, err);
      pstrb <= 4'hf;
      apb(1'b1, 12'h020, 32'hffff_ffff, rd, err);
      check("unmapped write error", {31'h0, err}, 32'h1);
      apb(1'b0, `OFSEL_REG_CTRL, 32'h0, rd, err);
      check("ctrl strobes", rd, 32'h0003_0c0f);
      drive_check(15, 12, 1'b0, 3);
      check("load closures", {31'h0, load_closes > 0}, 32'h1);
      check("aux closures", {31'h0, aux_closes > 0}, 32'h1);
      final_report;
   end
endmodule
